/* design/adm_ctrl.sv */
// Functional notes
// - normal results land in eight upper/lower byte pairs, one per slot
// - top-priority result goes to its own upper/lower pair
// - one bit picks fixed or scan, another single or repeat
// - fixed repeat: done every 1, 4 or 8 conversions; code 11 refused
// - normal busy flag reads 1 while conversion runs
// - channel field: fixed input, or scan range from group base; 1100+ refused
// - priority done flag: 0 before or during, 1 after completion
// - writing 1 starts priority conversion; 0 ignored; reads 0
`timescale 1ns/1ps
`include "adm_params.svh"
module adm_ctrl (
    // clock and reset
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // axi4-lite write
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire adm_pkg::adm_addr_t awaddr,
    input  wire logic               wvalid,
    output logic                    wready,
    input  wire adm_pkg::adm_word_t wdata,
    input  wire logic [3:0]         wstrb,
    output logic                    bvalid,
    input  wire logic               bready,
    output logic [1:0]              bresp,
    // axi4-lite read
    input  wire logic               arvalid,
    output logic                    arready,
    input  wire adm_pkg::adm_addr_t araddr,
    output logic                    rvalid,
    input  wire logic               rready,
    output adm_pkg::adm_word_t      rdata,
    output logic [1:0]              rresp,
    // converter core
    output logic                    conv_start_r,
    output logic [3:0]              conv_channel_r,
    input  wire logic               conv_done,
    input  wire adm_pkg::adm_res_t  conv_result,
    output logic                    ref_enable,
    output logic                    idle_operation,
    // interrupt
    output logic                    irq_r
);
    import adm_pkg::*;

    // ------------------------------------
    // declarations
    // ------------------------------------
    logic        wr_en;
    adm_addr_t   wr_addr;
    adm_word_t   wr_data;
    logic [3:0]  wr_strb;
    logic        wr_hit;
    logic        rd_en;
    adm_word_t   rd_data;
    logic        rd_hit;
    adm_state_e  st_r;
    // mode fields
    logic        scan_r;
    logic        repeat_r;
    logic [1:0]  itm_r;
    logic [3:0]  adch_r;
    logic        scan8_r;
    logic        vref_r;
    logic        idle_r;
    logic [3:0]  hpch_r;
    // sequencing state
    logic        start_pend_r;
    logic        normal_busy_r;
    logic        normal_done_r;
    logic [3:0]  seq_ch_r;
    logic [2:0]  cnt_r;
    logic        prio_pend_r;
    logic        prio_busy_r;
    logic        prio_done_r;
    adm_res_t    res_r [`ADM_SLOTS];
    adm_res_t    prio_res_r;
    logic [1:0]  stat_r;
    logic [1:0]  mask_r;
    // decode and helpers
    logic        wr_mod0;
    logic        wr_mod1;
    logic        wr_mod2;
    logic        wr_mask;
    logic        rd_mod0;
    logic        rd_stat;
    logic [3:0]  base_ch;
    logic        seq_last;
    logic        fixed_rep;
    logic [2:0]  cnt_top;
    logic        cnt_last;
    logic        norm_end;
    logic        prio_end;
    logic        norm_set;
    logic [2:0]  norm_slot;
    logic        mode_ok;
    logic        res_sel;
    adm_addr_t   rd_off;
    adm_res_t    rd_res;

    // ------------------------------------
    // bus slave
    // ------------------------------------
    adm_axil_slave u_bus (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awvalid (awvalid),
        .awready (awready),
        .awaddr  (awaddr),
        .wvalid  (wvalid),
        .wready  (wready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .bvalid  (bvalid),
        .bready  (bready),
        .bresp   (bresp),
        .arvalid (arvalid),
        .arready (arready),
        .rvalid  (rvalid),
        .rready  (rready),
        .rdata   (rdata),
        .rresp   (rresp),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_hit  (wr_hit),
        .rd_en   (rd_en),
        .rd_data (rd_data),
        .rd_hit  (rd_hit)
    );

    // write decode; only byte lane 0 carries register bits
    assign wr_mod0 = wr_en && wr_strb[0] && wr_addr == `ADM_OFF_MOD0;
    assign wr_mod1 = wr_en && wr_strb[0] && wr_addr == `ADM_OFF_MOD1;
    assign wr_mod2 = wr_en && wr_strb[0] && wr_addr == `ADM_OFF_MOD2;
    assign wr_mask = wr_en && wr_strb[0] && wr_addr == `ADM_OFF_MASK;
    assign wr_hit  = wr_addr == `ADM_OFF_MOD0 || wr_addr == `ADM_OFF_MOD1
                  || wr_addr == `ADM_OFF_MOD2 || wr_addr == `ADM_OFF_MASK;
    assign rd_mod0 = rd_en && araddr == `ADM_OFF_MOD0;
    assign rd_stat = rd_en && araddr == `ADM_OFF_STAT;

    // ------------------------------------
    // sequencing helpers
    // ------------------------------------
    // scan group base: 0/4/8 in 4-wide scan, 0/8 in 8-wide scan
    assign base_ch   = scan8_r ? {adch_r[3], 3'h0} : {adch_r[3:2], 2'h0};
    assign seq_last  = seq_ch_r == adch_r;
    assign fixed_rep = !scan_r && repeat_r;
    assign cnt_top   = itm_r == `ADM_ITM_4 ? `ADM_CNT_4 :
                       itm_r == `ADM_ITM_8 ? `ADM_CNT_8 : `ADM_CNT_1;
    assign cnt_last  = cnt_r == cnt_top;
    assign norm_end  = st_r == ADM_ST_NORM && conv_done;
    assign prio_end  = st_r == ADM_ST_PRIO && conv_done;
    // completion point: end of scan pass, interval, or single shot
    assign norm_set  = norm_end && (scan_r ? seq_last :
                       (repeat_r ? cnt_last : 1'b1));
    assign norm_slot = fixed_rep ? cnt_r : seq_ch_r[2:0];
    // prohibited channel codes and interval code refuse the start
    assign mode_ok   = adch_r <= `ADM_CH_MAX
                    && !(fixed_rep && itm_r > `ADM_ITM_8);

    // ------------------------------------
    // mode registers
    // ------------------------------------
    // mode fields take effect on the write itself
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scan_r   <= 1'b0;
            repeat_r <= 1'b0;
            itm_r    <= `ADM_ITM_1;
        end else if (wr_mod0) begin
            scan_r   <= wr_data[`ADM_B_SCAN];
            repeat_r <= wr_data[`ADM_B_REPEAT];
            itm_r    <= wr_data[`ADM_B_ITM_HI:`ADM_B_ITM_LO];
        end
    end

    // reference, idle and channel selection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vref_r  <= 1'b0;
            idle_r  <= 1'b0;
            scan8_r <= 1'b0;
            adch_r  <= '0;
        end else if (wr_mod1) begin
            vref_r  <= wr_data[`ADM_B_VREF];
            idle_r  <= wr_data[`ADM_B_IDLE];
            scan8_r <= wr_data[`ADM_B_SCAN8];
            adch_r  <= wr_data[`ADM_B_CH_HI:`ADM_B_CH_LO];
        end
    end

    // priority channel and interrupt mask
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hpch_r <= '0;
            mask_r <= '0;
        end else begin
            if (wr_mod2)
                hpch_r <= wr_data[`ADM_B_CH_HI:`ADM_B_CH_LO];
            if (wr_mask)
                mask_r <= wr_data[1:0];
        end
    end

    assign ref_enable     = vref_r;
    assign idle_operation = idle_r;

    // ------------------------------------
    // normal conversion control
    // ------------------------------------
    // start launches a cycle after the write so that mode fields written
    // in the same word are already in place
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_pend_r  <= 1'b0;
            normal_busy_r <= 1'b0;
            seq_ch_r      <= '0;
            cnt_r         <= '0;
        end else if (start_pend_r) begin
            start_pend_r  <= 1'b0;
            normal_busy_r <= mode_ok;
            seq_ch_r      <= scan_r ? base_ch : adch_r;
            cnt_r         <= '0;
        end else if (wr_mod0 && wr_data[`ADM_B_START] && !normal_busy_r) begin
            start_pend_r  <= 1'b1;
        end else if (norm_end) begin
            if (scan_r) begin
                seq_ch_r <= seq_last ? base_ch : seq_ch_r + 4'h1;
                if (seq_last && !repeat_r)
                    normal_busy_r <= 1'b0;
            end else if (repeat_r) begin
                cnt_r <= cnt_last ? `ADM_CNT_1 : cnt_r + 3'h1;
            end else begin
                normal_busy_r <= 1'b0;
            end
        end
    end

    // done flag: completion wins over a clearing read
    always_ff @(posedge aclk) begin
        if (!aresetn)
            normal_done_r <= 1'b0;
        else if (norm_set)
            normal_done_r <= 1'b1;
        else if (start_pend_r || rd_mod0)
            normal_done_r <= 1'b0;
    end

    // ------------------------------------
    // top-priority conversion control
    // ------------------------------------
    // a priority request waits only for the conversion in flight
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prio_pend_r <= 1'b0;
            prio_busy_r <= 1'b0;
            prio_done_r <= 1'b0;
        end else if (wr_mod2 && wr_data[`ADM_B_PSTART] && !prio_busy_r
                     && wr_data[`ADM_B_CH_HI:`ADM_B_CH_LO] <= `ADM_HP_MAX) begin
            prio_pend_r <= 1'b1;
            prio_busy_r <= 1'b1;
            prio_done_r <= 1'b0;
        end else if (prio_end) begin
            prio_busy_r <= 1'b0;
            prio_done_r <= 1'b1;
        end else if (st_r == ADM_ST_IDLE && prio_pend_r) begin
            prio_pend_r <= 1'b0;
        end
    end

    // ------------------------------------
    // converter sequencer
    // ------------------------------------
    // one conversion at a time; priority goes first at each gap
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r           <= ADM_ST_IDLE;
            conv_start_r   <= 1'b0;
            conv_channel_r <= '0;
        end else begin
            conv_start_r <= 1'b0;
            case (st_r)
                ADM_ST_IDLE: begin
                    if (prio_pend_r) begin
                        st_r           <= ADM_ST_PRIO;
                        conv_start_r   <= 1'b1;
                        conv_channel_r <= hpch_r;
                    end else if (normal_busy_r && !start_pend_r) begin
                        st_r           <= ADM_ST_NORM;
                        conv_start_r   <= 1'b1;
                        conv_channel_r <= seq_ch_r;
                    end
                end
                ADM_ST_NORM, ADM_ST_PRIO: begin
                    if (conv_done)
                        st_r <= ADM_ST_IDLE;
                end
                default: st_r <= ADM_ST_IDLE;
            endcase
        end
    end

    // ------------------------------------
    // result storage
    // ------------------------------------
    for (genvar i = 0; i < `ADM_SLOTS; i++) begin : g_slot
        always_ff @(posedge aclk) begin
            if (!aresetn)
                res_r[i] <= '0;
            else if (norm_end && norm_slot == 3'(i))
                res_r[i] <= conv_result;
        end
    end

    // kept apart so a priority result never overwrites a slot
    always_ff @(posedge aclk) begin
        if (!aresetn)
            prio_res_r <= '0;
        else if (prio_end)
            prio_res_r <= conv_result;
    end

    // ------------------------------------
    // interrupt status and output
    // ------------------------------------
    // sticky events, cleared by reading; a new event beats the clear
    always_ff @(posedge aclk) begin
        if (!aresetn)
            stat_r <= '0;
        else
            stat_r <= {prio_end, norm_set} | (rd_stat ? 2'h0 : stat_r);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            irq_r <= 1'b0;
        else
            irq_r <= |(stat_r & mask_r);
    end

    // ------------------------------------
    // read mux
    // ------------------------------------
    assign rd_off  = araddr - `ADM_OFF_RES;
    assign res_sel = araddr >= `ADM_OFF_RES && araddr <= `ADM_OFF_RESL
                  && araddr[1:0] == 2'h0;
    assign rd_res  = araddr == `ADM_OFF_PRES ? prio_res_r : res_r[rd_off[4:2]];

    // start bits and reserved bits always read zero
    always_comb begin
        rd_data = '0;
        rd_hit  = 1'b1;
        case (araddr)
            `ADM_OFF_MOD0: begin
                rd_data[`ADM_B_NDONE]  = normal_done_r;
                rd_data[`ADM_B_NBUSY]  = normal_busy_r;
                rd_data[`ADM_B_ITM_HI:`ADM_B_ITM_LO] = itm_r;
                rd_data[`ADM_B_REPEAT] = repeat_r;
                rd_data[`ADM_B_SCAN]   = scan_r;
            end
            `ADM_OFF_MOD1: begin
                rd_data[`ADM_B_VREF]  = vref_r;
                rd_data[`ADM_B_IDLE]  = idle_r;
                rd_data[`ADM_B_SCAN8] = scan8_r;
                rd_data[`ADM_B_CH_HI:`ADM_B_CH_LO] = adch_r;
            end
            `ADM_OFF_MOD2: begin
                rd_data[`ADM_B_PDONE] = prio_done_r;
                rd_data[`ADM_B_PBUSY] = prio_busy_r;
                rd_data[`ADM_B_CH_HI:`ADM_B_CH_LO] = hpch_r;
            end
            `ADM_OFF_STAT: rd_data[1:0] = stat_r;
            `ADM_OFF_MASK: rd_data[1:0] = mask_r;
            default: begin
                // lower byte holds the two low bits, upper the eight high
                if (res_sel || araddr == `ADM_OFF_PRES)
                    rd_data[15:0] = {rd_res[9:2], rd_res[1:0], 6'h00};
                else
                    rd_hit = 1'b0;
            end
        endcase
    end

    // ------------------------------------
    // assertions
    // ------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_SLOT_STORE: assert property (
        norm_end |=> res_r[$past(norm_slot)] == $past(conv_result))
        else $error("normal result not stored in its slot");

    AST_PRIO_STORE: assert property (
        prio_end |=> prio_res_r == $past(conv_result) && !prio_busy_r)
        else $error("priority result not stored");

    AST_SINGLE_END: assert property (
        norm_end && !scan_r && !repeat_r |=> !normal_busy_r && normal_done_r)
        else $error("single fixed conversion did not finish");

    AST_ITM_FOUR: assert property (
        norm_end && fixed_rep && itm_r == `ADM_ITM_4 && cnt_r == `ADM_CNT_4
        |=> normal_done_r && cnt_r == `ADM_CNT_1)
        else $error("four-conversion interval not honoured");

    AST_NORM_BUSY: assert property (
        st_r == ADM_ST_NORM |-> normal_busy_r)
        else $error("normal conversion running without busy");

    AST_SCAN_RANGE: assert property (
        conv_start_r && st_r == ADM_ST_NORM && scan_r
        |-> conv_channel_r <= adch_r && conv_channel_r >= base_ch)
        else $error("scan channel out of range");

    AST_PRIO_LAUNCH: assert property (
        st_r == ADM_ST_IDLE && prio_pend_r
        |=> conv_start_r && conv_channel_r == $past(hpch_r) ##1 !conv_start_r)
        else $error("priority conversion not launched");

    AST_PRIO_FLAGS: assert property (
        prio_busy_r |-> !prio_done_r)
        else $error("priority done set while busy");

    AST_PRIO_BUSY: assert property (
        st_r == ADM_ST_PRIO |-> prio_busy_r)
        else $error("priority conversion running without busy");
endmodule

/* design/adm_params.svh */
`ifndef ADM_PARAMS_SVH
`define ADM_PARAMS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define ADM_OFF_MOD0  8'h04
`define ADM_OFF_MOD1  8'h08
`define ADM_OFF_MOD2  8'h0C
`define ADM_OFF_RES   8'h30
`define ADM_OFF_RESL  8'h4C
`define ADM_OFF_PRES  8'h50
`define ADM_OFF_STAT  8'h60
`define ADM_OFF_MASK  8'h64

// ----------------------------------------
// field positions
// ----------------------------------------
`define ADM_B_NDONE   7
`define ADM_B_NBUSY   6
`define ADM_B_ITM_HI  5
`define ADM_B_ITM_LO  4
`define ADM_B_REPEAT  3
`define ADM_B_SCAN    2
`define ADM_B_START   0
`define ADM_B_VREF    7
`define ADM_B_IDLE    6
`define ADM_B_SCAN8   5
`define ADM_B_PDONE   7
`define ADM_B_PBUSY   6
`define ADM_B_PSTART  5
`define ADM_B_CH_HI   3
`define ADM_B_CH_LO   0

// ----------------------------------------
// reset values, codes and limits
// ----------------------------------------
`define ADM_RST8      8'h00
`define ADM_ITM_1     2'h0
`define ADM_ITM_4     2'h1
`define ADM_ITM_8     2'h2
`define ADM_CNT_1     3'h0
`define ADM_CNT_4     3'h3
`define ADM_CNT_8     3'h7
`define ADM_CH_MAX    4'hB
`define ADM_HP_MAX    4'hC
`define ADM_SLOTS     8
`define ADM_RESP_OK   2'h0
`define ADM_RESP_ERR  2'h2

`endif

/* design/adm_pkg.sv */
package adm_pkg;
    typedef enum logic [2:0] {
        ADM_ST_IDLE = 3'b001,
        ADM_ST_NORM = 3'b010,
        ADM_ST_PRIO = 3'b100
    } adm_state_e;
    typedef logic [9:0]  adm_res_t;
    typedef logic [7:0]  adm_addr_t;
    typedef logic [31:0] adm_word_t;
endpackage

/* design/adm_axil_slave.sv */
`timescale 1ns/1ps
`include "adm_params.svh"
module adm_axil_slave (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // write channels
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire adm_pkg::adm_addr_t awaddr,
    input  wire logic              wvalid,
    output logic                   wready,
    input  wire adm_pkg::adm_word_t wdata,
    input  wire logic [3:0]        wstrb,
    output logic                   bvalid,
    input  wire logic              bready,
    output logic [1:0]             bresp,
    // read channels
    input  wire logic              arvalid,
    output logic                   arready,
    output logic                   rvalid,
    input  wire logic              rready,
    output adm_pkg::adm_word_t     rdata,
    output logic [1:0]             rresp,
    // register file side
    output logic                   wr_en,
    output adm_pkg::adm_addr_t     wr_addr,
    output adm_pkg::adm_word_t     wr_data,
    output logic [3:0]             wr_strb,
    input  wire logic              wr_hit,
    output logic                   rd_en,
    input  wire adm_pkg::adm_word_t rd_data,
    input  wire logic              rd_hit
);
    import adm_pkg::*;

    logic aw_got_r;
    logic w_got_r;

    // write strobe once both halves are held, one per response
    assign wr_en = aw_got_r & w_got_r & ~bvalid;
    assign rd_en = arvalid & arready;

    // address channel: hold address until the response is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready  <= 1'b1;
            aw_got_r <= 1'b0;
            wr_addr  <= '0;
        end else if (awvalid && awready) begin
            awready  <= 1'b0;
            aw_got_r <= 1'b1;
            wr_addr  <= awaddr;
        end else if (bvalid && bready) begin
            awready  <= 1'b1;
            aw_got_r <= 1'b0;
        end
    end

    // data channel, independent of address order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready  <= 1'b1;
            w_got_r <= 1'b0;
            wr_data <= '0;
            wr_strb <= '0;
        end else if (wvalid && wready) begin
            wready  <= 1'b0;
            w_got_r <= 1'b1;
            wr_data <= wdata;
            wr_strb <= wstrb;
        end else if (bvalid && bready) begin
            wready  <= 1'b1;
            w_got_r <= 1'b0;
        end
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= `ADM_RESP_OK;
        end else if (wr_en) begin
            bvalid <= 1'b1;
            bresp  <= wr_hit ? `ADM_RESP_OK : `ADM_RESP_ERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // read: data captured at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= `ADM_RESP_OK;
        end else if (rd_en) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_data;
            rresp   <= rd_hit ? `ADM_RESP_OK : `ADM_RESP_ERR;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
        end
    end
endmodule

/* tb/adm_core_model.sv */
`timescale 1ns/1ps
module adm_core_model #(
    parameter int LAT = 12
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // converter link
    input  wire logic              conv_start_r,
    input  wire logic [3:0]        conv_channel_r,
    output logic                   conv_done,
    output adm_pkg::adm_res_t      conv_result
);
    import adm_pkg::*;
    int cnt_r;
    // ----------------------------------------
    // slow core: done pulses LAT cycles on
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) cnt_r <= 0;
        else if (conv_start_r) cnt_r <= LAT;
        else if (cnt_r != 0) cnt_r <= cnt_r - 1;
    end
    assign conv_done = (cnt_r == 1);
    // inverted outside done, so stale data never passes
    assign conv_result = conv_done ? {conv_channel_r, 6'h25} : ~{conv_channel_r, 6'h25};
endmodule

/* tb/adm_ctrl_tb.sv */
`timescale 1ns/1ps
module adm_ctrl_tb;
    import adm_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, conv_start_r, conv_done;
    logic ref_enable, idle_operation, irq_r;
    adm_addr_t awaddr, araddr;
    adm_word_t wdata, rdata, v;
    logic [3:0] wstrb, conv_channel_r;
    logic [1:0] bresp, rresp, r;
    adm_res_t conv_result;
    int fails = 0, n_checks = 0;
    // ----------------------------------------
    // clock, design and core
    // ----------------------------------------
    always #12.5 aclk = ~aclk;
    adm_ctrl dut (.*);
    adm_core_model core (.*);
    task print_verdict;
        if (fails == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task chk(input logic [31:0] s, e);
        n_checks++;
        if (s !== e) begin
            fails++;
            $display("mismatch %0t got %h exp %h", $time, s, e);
        end
    endtask
    task tmo;
        fails++;
        print_verdict;
    endtask
    // ready sampled at negedge, released after the taking edge
    task wr(input adm_addr_t a, input adm_word_t d);
        int n;
        logic ha, hw, hb;
        hb = 0;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        for (n = 0; !hb && n < 50; n++) begin
            @(negedge aclk);
            ha = awvalid & awready; hw = wvalid & wready; hb = bvalid; r = bresp;
            @(posedge aclk);
            if (ha) awvalid <= 0;
            if (hw) wvalid <= 0;
            if (hb) bready <= 0;
        end
        if (!hb) tmo;
        @(negedge aclk); // outputs launched at the response edge have settled
    endtask
    task rd(input adm_addr_t a);
        int n;
        logic ha, hr;
        hr = 0;
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        for (n = 0; !hr && n < 50; n++) begin
            @(negedge aclk);
            ha = arready; hr = rvalid; v = rdata; r = rresp;
            @(posedge aclk);
            if (ha) arvalid <= 0;
            if (hr) rready <= 0;
        end
        if (!hr) tmo;
    endtask
    // poll a register until bit b is set
    task pl(input adm_addr_t a, input int b);
        int n;
        for (n = 0; n < 40; n++) begin
            rd(a);
            if (v[b] === 1'b1) break;
        end
        if (n == 40) tmo;
    endtask
    function automatic adm_word_t rw(input logic [3:0] c);
        adm_res_t x;
        x = {c, 6'h25};
        return {16'h0000, x[9:2], x[1:0], 6'h00};
    endfunction
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hF;
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        for (int i = 1; i < 4; i++) begin
            rd(8'(4 * i)); chk(v, 32'h0);
        end
        rd(8'h20); chk(v, 32'h0); chk(32'(r), 32'h2);
        wr(8'h24, 32'h1); chk(r, 2'h2);
        wr(8'h08, 32'h82); chk(ref_enable, 1'b1);
        repeat (120) @(posedge aclk);
        wr(8'h04, 32'h00);
        wr(8'h04, 32'h01);
        repeat (2) @(posedge aclk);
        rd(8'h04); chk(v, 32'h40);
        pl(8'h04, 7); chk(v, 32'h80);
        rd(8'h38); chk(v, rw(2));
        chk(irq_r, 1'b0);
        wr(8'h64, 32'h3); chk(irq_r, 1'b1);
        rd(8'h60); chk(v, 32'h1);
        rd(8'h60); chk(v, 32'h0); chk(32'(irq_r), 32'h0);
        wr(8'h08, 32'h86); wr(8'h04, 32'h04); wr(8'h04, 32'h05);
        pl(8'h04, 7);
        for (int c = 4; c < 7; c++) begin
            rd(8'h30 + 8'(4 * c)); chk(v, rw(4'(c)));
        end
        rd(8'h60);
        wr(8'h0C, 32'h23); rd(8'h0C); chk(v & 32'hA0, 32'h0);
        pl(8'h0C, 7); chk(v, 32'h83);
        rd(8'h50); chk(v, rw(3));
        rd(8'h60); chk(v, 32'h2);
        // fixed repeat, done every 4; clearing repeat ends after the next one
        wr(8'h08, 32'h81); wr(8'h04, 32'h18); wr(8'h04, 32'h19);
        pl(8'h04, 7); chk(v, 32'hD8);
        wr(8'h04, 32'h10); pl(8'h04, 7); chk(v, 32'h90);
        rd(8'h3C); chk(v, rw(1));
        // 8-wide scan from base 8 to input 9, slots 0 and 1
        wr(8'h08, 32'hA9); wr(8'h04, 32'h04); wr(8'h04, 32'h05);
        pl(8'h04, 7);
        rd(8'h30); chk(v, rw(8));
        rd(8'h34); chk(v, rw(9));
        wr(8'h08, 32'h8D); wr(8'h04, 32'h01); repeat (2) @(posedge aclk);
        rd(8'h04); chk(v, 32'h0);
        wr(8'h08, 32'h85); wr(8'h04, 32'h39); repeat (2) @(posedge aclk);
        rd(8'h04); chk(v, 32'h38);
        wr(8'h08, 32'h40); chk(32'({ref_enable, idle_operation}), 32'h1);
        print_verdict;
    end
endmodule
